// ---- verilog/step_ctl_pkg.sv ----
// Constants and carrier types for the stepper serial front end.
// Assumes a single 25 MHz system clock and 4-bit coil current codes.
package step_ctl_pkg;
  localparam int CMD_W = 12;
  localparam int STAT_W = 12;
  localparam logic [3:0] CUR_ZERO = 4'h0;
  localparam logic [3:0] CUR_FULL = 4'hF;
  // Open load is flagged after more than this many oscillator cycles
  localparam logic [4:0] OL_LIMIT = 5'h0E;
  localparam logic [3:0] BITS_MIN = 4'hC;
  // Bit positions in the command word
  localparam int POS_MIX_A = 11;
  localparam int POS_CUR_A = 7;
  localparam int POS_POL_A = 6;
  localparam int POS_MIX_B = 5;
  localparam int POS_CUR_B = 1;
  localparam int POS_POL_B = 0;
  localparam logic [11:0] CMD_RESET = 12'h000;
  localparam logic [2:0] STAT_FIXED = 3'h0;

  typedef struct packed {
    logic mix;
    logic [3:0] current;
    logic polarity;
  } bridge_cfg_t;

  typedef struct packed {
    bridge_cfg_t a;
    bridge_cfg_t b;
  } coil_cmd_t;

  typedef struct packed {
    logic over_temp;
    logic temp_warn;
    logic under_volt;
    logic oc_high;
    logic oc_a;
    logic oc_b;
  } fault_t;
endpackage

// ---- verilog/sync_2ff.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs may change at any time relative to clk.
`timescale 1ns/100ps
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ---- verilog/open_load_mon.sv ----
// Open load watchdog for one bridge, counted in chopper oscillator cycles.
// Assumes osc_tick and pwm_off are single-cycle pulses in the clk domain.
`timescale 1ns/100ps
module open_load_mon
  import step_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Chopper events
  input wire logic osc_tick,
  input wire logic pwm_off,
  input wire logic active,
  // Result
  output logic open_load
);
  logic [4:0] cnt_r, cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!active || pwm_off) begin
      cnt_nxt = 5'h00;
    end else if (osc_tick && cnt_r <= OL_LIMIT) begin
      cnt_nxt = cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // More than the limit, not equal to it
  assign open_load = active && (cnt_r > OL_LIMIT);
endmodule

// ---- verilog/step_serial_ctl.sv ----
// Serial command front end and mode logic for a two-coil stepper driver.
// Assumes the host drives the serial pins asynchronously; clk oversamples
// them well above the serial clock rate. Chopper analog parts live outside.
`timescale 1ns/100ps
module step_serial_ctl
  import step_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link and mode pins
  input wire logic sck,
  input wire logic sdi,
  input wire logic csn_low,
  input wire logic chip_enable_low,
  input wire logic serial_mode_select,
  input wire logic analog_base_select,
  output logic sdo_out,
  output logic sdo_oe,
  // Chopper side
  input wire logic osc_in,
  input wire logic sense_input_a,
  input wire logic sense_input_b,
  input wire logic pwm_off_a,
  input wire logic pwm_off_b,
  input wire logic [2:0] load_level,
  input wire logic vcc_undervolt,
  input wire fault_t faults,
  output bridge_cfg_t bridge_a,
  output bridge_cfg_t bridge_b,
  output logic chop_on_a,
  output logic chop_on_b,
  output logic restart_a,
  output logic restart_b,
  output logic gates_enable,
  output logic osc_enable,
  output logic refs_enable,
  output logic standby,
  output logic open_load_flag_a,
  output logic open_load_flag_b
);
  logic sck_s, sdi_s, csn_s, enn_s, spe_s, abs_s, osc_s, sna_s, snb_s, uv_s;

  sync_2ff #(.W(10)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({sck, sdi, csn_low, chip_enable_low, serial_mode_select,
        analog_base_select, osc_in, sense_input_a, sense_input_b, vcc_undervolt}),
    .q({sck_s, sdi_s, csn_s, enn_s, spe_s, abs_s, osc_s, sna_s, snb_s, uv_s})
  );

  // Edge history of the synchronised link and oscillator pins
  logic sck_d_r, csn_d_r, osc_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      csn_d_r <= 1'b1;
      osc_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      csn_d_r <= csn_s;
      osc_d_r <= osc_s;
    end
  end

  logic sck_rise, sck_fall, csn_rise, osc_rise, osc_fall;
  assign sck_rise = sck_s && !sck_d_r;
  assign sck_fall = !sck_s && sck_d_r;
  assign csn_rise = csn_s && !csn_d_r;
  assign osc_rise = osc_s && !osc_d_r;
  assign osc_fall = !osc_s && osc_d_r;

  logic serial_mode, link_reset;
  assign serial_mode = spe_s;
  // Serial logic held in reset in shutdown and in standalone mode
  assign link_reset = enn_s || !serial_mode;

  // Serial shift state: only link edges and link_reset move it
  logic [CMD_W-1:0] shift_r, shift_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic out_bit_r, out_bit_nxt;
  coil_cmd_t cmd_r, cmd_nxt;
  logic [STAT_W-1:0] stat_cap;

  always_comb begin
    shift_nxt = shift_r;
    bits_nxt = bits_r;
    out_bit_nxt = out_bit_r;
    cmd_nxt = cmd_r;
    if (link_reset) begin
      shift_nxt = CMD_RESET;
      bits_nxt = 4'h0;
      out_bit_nxt = 1'b0;
      cmd_nxt = CMD_RESET;
    end else if (csn_rise) begin
      // Short frames are spikes, keep the old settings
      if (bits_r >= BITS_MIN) begin
        cmd_nxt = shift_r;
      end
      bits_nxt = 4'h0;
    end else if (!csn_s) begin
      if (csn_d_r) begin
        // Frame start: load status word for readback
        shift_nxt = stat_cap;
        out_bit_nxt = stat_cap[STAT_W-1];
      end else if (sck_rise) begin
        shift_nxt = {shift_r[CMD_W-2:0], sdi_s};
        if (bits_r < BITS_MIN) begin
          bits_nxt = bits_r + 4'h1;
        end
      end else if (sck_fall) begin
        out_bit_nxt = shift_r[CMD_W-1];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= CMD_RESET;
      bits_r <= 4'h0;
      out_bit_r <= 1'b0;
      cmd_r <= CMD_RESET;
    end else begin
      shift_r <= shift_nxt;
      bits_r <= bits_nxt;
      out_bit_r <= out_bit_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  // Effective bridge configuration for either mode
  bridge_cfg_t eff_a, eff_b;
  logic zero_cmd, stby_req, fault_any;
  assign fault_any = faults.oc_a || faults.oc_b || faults.oc_high || faults.over_temp;

  always_comb begin
    if (serial_mode) begin
      eff_a = cmd_r.a;
      eff_b = cmd_r.b;
    end else begin
      eff_a = '{mix: !abs_s, current: CUR_FULL, polarity: sdi_s};
      eff_b = '{mix: !sck_s, current: CUR_FULL, polarity: csn_s};
    end
  end

  assign zero_cmd = serial_mode && cmd_r.a.current == CUR_ZERO && cmd_r.b.current == CUR_ZERO;
  // Disabled enable pin is standby in standalone, shutdown in serial mode
  assign stby_req = zero_cmd || uv_s || enn_s;

  // Registered outputs; whole config words move in one edge
  logic stby_r, stby_nxt;
  bridge_cfg_t out_a_r, out_a_nxt, out_b_r, out_b_nxt;
  logic rst_a_r, rst_a_nxt, rst_b_r, rst_b_nxt;
  logic on_a_r, on_a_nxt, on_b_r, on_b_nxt;
  logic oc_clr_r, oc_clr_nxt;
  logic gate_en_r, gate_en_nxt, refs_r, refs_nxt;

  always_comb begin
    stby_nxt = stby_req;
    out_a_nxt = eff_a;
    out_b_nxt = eff_b;
    rst_a_nxt = !stby_req && (eff_a.polarity != out_a_r.polarity);
    rst_b_nxt = !stby_req && (eff_b.polarity != out_b_r.polarity);
    on_a_nxt = on_a_r;
    on_b_nxt = on_b_r;
    oc_clr_nxt = zero_cmd || (!serial_mode && enn_s);
    gate_en_nxt = !stby_req;
    refs_nxt = !(serial_mode && enn_s);
    if (stby_req || eff_a.current == CUR_ZERO || rst_a_nxt) begin
      on_a_nxt = 1'b0;
    end else if (osc_rise) begin
      on_a_nxt = !sna_s;
    end else if (pwm_off_a) begin
      on_a_nxt = 1'b0;
    end
    // Bridge B chops on the opposite oscillator edge
    if (stby_req || eff_b.current == CUR_ZERO || rst_b_nxt) begin
      on_b_nxt = 1'b0;
    end else if (osc_fall) begin
      on_b_nxt = !snb_s;
    end else if (pwm_off_b) begin
      on_b_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stby_r <= 1'b1;
      out_a_r <= '0;
      out_b_r <= '0;
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
      on_a_r <= 1'b0;
      on_b_r <= 1'b0;
      oc_clr_r <= 1'b0;
      gate_en_r <= 1'b0;
      refs_r <= 1'b1;
    end else begin
      stby_r <= stby_nxt;
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      rst_a_r <= rst_a_nxt;
      rst_b_r <= rst_b_nxt;
      on_a_r <= on_a_nxt;
      on_b_r <= on_b_nxt;
      oc_clr_r <= oc_clr_nxt;
      gate_en_r <= gate_en_nxt;
      refs_r <= refs_nxt;
    end
  end

  // Open load watch, suspended at zero current and in standby
  logic ol_a, ol_b, osc_tick_a, osc_tick_b;
  assign osc_tick_a = osc_rise && !stby_r;
  assign osc_tick_b = osc_fall && !stby_r;

  open_load_mon u_ol_a (
    .clk(clk),
    .rst(rst),
    .osc_tick(osc_tick_a),
    .pwm_off(pwm_off_a),
    .active(out_a_r.current != CUR_ZERO && !stby_r),
    .open_load(ol_a)
  );

  open_load_mon u_ol_b (
    .clk(clk),
    .rst(rst),
    .osc_tick(osc_tick_b),
    .pwm_off(pwm_off_b),
    .active(out_b_r.current != CUR_ZERO && !stby_r),
    .open_load(ol_b)
  );

  // Overcurrent flags of bridges A and B are masked from the cycle after a clear until one cycle after it ends
  logic oc_a_vis, oc_b_vis, flt_cond;
  assign oc_a_vis = faults.oc_a && !oc_clr_r;
  assign oc_b_vis = faults.oc_b && !oc_clr_r;
  assign flt_cond = oc_a_vis || oc_b_vis || faults.under_volt || faults.over_temp;

  logic ola_r, ola_nxt, olb_r, olb_nxt;
  always_comb begin
    ola_nxt = 1'b0;
    olb_nxt = 1'b0;
    if (out_a_r.current != CUR_ZERO) begin
      ola_nxt = ol_a || flt_cond;
    end
    if (out_b_r.current != CUR_ZERO) begin
      olb_nxt = ol_b || flt_cond;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ola_r <= 1'b0;
      olb_r <= 1'b0;
    end else begin
      ola_r <= ola_nxt;
      olb_r <= olb_nxt;
    end
  end

  assign stat_cap = {load_level, 1'b1, faults.over_temp, faults.temp_warn, faults.under_volt,
                     faults.oc_high, olb_r, ola_r, oc_b_vis, oc_a_vis};

  // Data out pin: driven error in standalone, else only inside a frame
  logic sdo_r, sdo_nxt, oe_r, oe_nxt;
  always_comb begin
    if (!serial_mode) begin
      sdo_nxt = fault_any && !enn_s;
      oe_nxt = 1'b1;
    end else begin
      sdo_nxt = out_bit_r;
      oe_nxt = !csn_s && !enn_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sdo_out = sdo_r;
  assign sdo_oe = oe_r;
  assign bridge_a = out_a_r;
  assign bridge_b = out_b_r;
  assign chop_on_a = on_a_r;
  assign chop_on_b = on_b_r;
  assign restart_a = rst_a_r;
  assign restart_b = rst_b_r;
  assign standby = stby_r;
  assign gates_enable = gate_en_r;
  assign osc_enable = gate_en_r;
  assign refs_enable = refs_r;
  assign open_load_flag_a = ola_r;
  assign open_load_flag_b = olb_r;

  standby_gates_a: assert property (@(posedge clk) disable iff (rst)
    stby_r |-> !on_a_r && !on_b_r && !gates_enable)
    else $error("chopper active in standby");
  zero_flag_a: assert property (@(posedge clk) disable iff (rst)
    out_a_r.current == CUR_ZERO |=> !ola_r)
    else $error("open load A set at zero current");
  sdo_release_a: assert property (@(posedge clk) disable iff (rst)
    serial_mode && $past(serial_mode) && $past(csn_s) |-> !sdo_oe)
    else $error("data out driven with select high");
  short_frame_a: assert property (@(posedge clk) disable iff (rst)
    csn_rise && bits_r < BITS_MIN && !link_reset |=> $stable(cmd_r))
    else $error("short frame changed command");
  zero_stby_a: assert property (@(posedge clk) disable iff (rst)
    zero_cmd |=> stby_r)
    else $error("zero currents did not enter standby");
  uv_stby_a: assert property (@(posedge clk) disable iff (rst)
    uv_s |=> stby_r)
    else $error("undervoltage without standby");
  pol_restart_a: assert property (@(posedge clk) disable iff (rst)
    rst_a_r |-> !on_a_r && out_a_r.polarity != $past(out_a_r.polarity))
    else $error("restart without polarity change");
  standalone_full_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && !serial_mode && !$past(serial_mode) |-> out_a_r.current == CUR_FULL && sdo_oe)
    else $error("standalone DAC not full or data out released");
  disable_clear_a: assert property (@(posedge clk) disable iff (rst)
    link_reset |=> cmd_r == CMD_RESET && bits_r == 4'h0)
    else $error("registers not cleared on disable");
endmodule

// ---- dv/spi_host_model.sv ----
// Behavioural serial host that frames commands for the stepper front end.
// Assumes the bench calls its tasks just after a clk edge.
`timescale 1ns/100ps
module spi_host_model (
  // Link pins
  output logic sck,
  output logic sdi,
  output logic csn_low,
  // Device answer
  input wire logic sdo_out,
  input wire logic sdo_oe
);
  logic [15:0] rx;
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    csn_low = 1'b1;
    rx = 16'h0000;
  end
  // One select per device, so chaining is never used here
  // Frames of up to 16 bits; dummy bits lead a wide frame
  task automatic send(input logic [15:0] w, input int n);
    #13 csn_low = 1'b0; // Low for the whole frame
    #320;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i]; // MSB first, stable over the rising edge
      #160 sck = 1'b1;
      rx = {rx[14:0], sdo_oe ? sdo_out : 1'bx};
      #160 sck = 1'b0;
    end
    #160 csn_low = 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    sdi = ~sdi;
    #200;
  endtask
  // Standalone mode uses the link pins as plain levels
  task automatic set_pins(input logic c, input logic d, input logic k);
    csn_low = c;
    sdi = d;
    sck = k;
  endtask
endmodule

// ---- dv/stepper_serial_control_modes_tb_top.sv ----
// Self-checking bench for the stepper serial front end and its modes.
// Assumes a 25 MHz clk and the host model driving the link pins.
`timescale 1ns/100ps
module stepper_serial_control_modes_tb_top
  import step_ctl_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1;
  logic sck, sdi, csn_low, sdo_out, sdo_oe;
  logic chip_enable_low = 1'b0, serial_mode_select = 1'b1, analog_base_select = 1'b1;
  logic sense_input_a = 1'b0, sense_input_b = 1'b0, pwm_off_a = 1'b0, pwm_off_b = 1'b0;
  logic vcc_undervolt = 1'b0, chop_on_a, chop_on_b, restart_a, restart_b;
  logic gates_enable, osc_enable, refs_enable, standby, open_load_flag_a, open_load_flag_b;
  logic [3:0] osc_ph = 4'h0;
  logic hit, hit_a;
  fault_t faults = '0;
  bridge_cfg_t bridge_a, bridge_b;
  int failures = 0, checks_done = 0, n;

  always #20 clk = ~clk;
  // Chopper oscillator of 16 clk periods, phase-locked to nothing on the link
  always @(posedge clk) osc_ph <= #1 osc_ph + 4'h1;

  spi_host_model host (.sck(sck), .sdi(sdi), .csn_low(csn_low), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe));
  step_serial_ctl dut (.clk(clk), .rst(rst), .sck(sck), .sdi(sdi), .csn_low(csn_low),
    .chip_enable_low(chip_enable_low), .serial_mode_select(serial_mode_select),
    .analog_base_select(analog_base_select), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .osc_in(osc_ph[3]), .sense_input_a(sense_input_a), .sense_input_b(sense_input_b),
    .pwm_off_a(pwm_off_a), .pwm_off_b(pwm_off_b), .load_level(3'h0),
    .vcc_undervolt(vcc_undervolt), .faults(faults), .bridge_a(bridge_a),
    .bridge_b(bridge_b), .chop_on_a(chop_on_a), .chop_on_b(chop_on_b),
    .restart_a(restart_a), .restart_b(restart_b), .gates_enable(gates_enable),
    .osc_enable(osc_enable), .refs_enable(refs_enable), .standby(standby),
    .open_load_flag_a(open_load_flag_a), .open_load_flag_b(open_load_flag_b));

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded watch for a level on a device output
  task automatic seen(ref logic s, input logic v, input int k, output logic h);
    h = 1'b0;
    repeat (k) begin
      tick(1);
      if (s === v) h = 1'b1;
    end
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    tick(6);
    rst = 1'b0;
    tick(10);
    check(sdo_oe, 1'b0);
    host.send(16'h0ABC, 12);
    tick(8);
    check(bridge_a, {1'b1, 4'h5, 1'b0});
    check(bridge_b, {1'b1, 4'hE, 1'b0});
    check(standby, 1'b0);
    fork
      host.send(16'hA123, 16);
      seen(restart_b, 1'b1, 170, hit);
      seen(restart_a, 1'b1, 170, hit_a);
    join
    check(hit, 1'b1);
    check(hit_a, 1'b0);
    check(host.rx[3:0], 4'hA);
    tick(8);
    check(bridge_a, {1'b0, 4'h2, 1'b0});
    check(bridge_b, {1'b1, 4'h1, 1'b1});
    host.send(16'h0FFF, 11);
    tick(8);
    check(bridge_a, {1'b0, 4'h2, 1'b0});
    // Flags are judged with the motor at standstill
    pwm_off_a = 1'b1;
    tick(1);
    pwm_off_a = 1'b0;
    tick(3);
    n = 4;
    while (open_load_flag_a !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    check({15'h0, n > 224 && n < 270}, 16'h1);
    pwm_off_a = 1'b1;
    tick(1);
    pwm_off_a = 1'b0;
    faults.oc_a = 1'b1;
    tick(4);
    check(open_load_flag_a, 1'b1);
    faults = '0;
    sense_input_a = 1'b1;
    tick(20);
    seen(chop_on_a, 1'b1, 40, hit);
    check(hit, 1'b0);
    sense_input_a = 1'b0;
    seen(chop_on_a, 1'b1, 40, hit);
    check(hit, 1'b1);
    host.send(16'h001E, 12);
    tick(300);
    check({open_load_flag_a, chop_on_a, standby}, 3'h0);
    check(chop_on_b, 1'b1);
    check(open_load_flag_b, 1'b1);
    host.send(16'h0000, 12);
    tick(8);
    check(standby, 1'b1);
    check({gates_enable, osc_enable}, 2'h0);
    host.send(16'h0ABC, 12);
    vcc_undervolt = 1'b1;
    tick(8);
    check(standby, 1'b1);
    vcc_undervolt = 1'b0;
    tick(8);
    check(standby, 1'b0);
    chip_enable_low = 1'b1;
    tick(6);
    check({standby, refs_enable, sdo_oe}, 3'h4);
    check(bridge_b, 6'h00);
    chip_enable_low = 1'b0;
    serial_mode_select = 1'b0;
    // Low level on sck enables mixing here, opposite to the command bit
    host.set_pins(1'b1, 1'b0, 1'b0);
    faults.over_temp = 1'b1;
    tick(8);
    check(bridge_a, {1'b0, 4'hF, 1'b0});
    check(bridge_b, {1'b1, 4'hF, 1'b1});
    check({sdo_oe, sdo_out}, 2'h3);
    analog_base_select = 1'b0;
    tick(6);
    check(bridge_a.mix, 1'b1);
    chip_enable_low = 1'b1;
    tick(6);
    check(standby, 1'b1);
    check({sdo_oe, sdo_out}, 2'h2);
    faults = '0;
    chip_enable_low = 1'b0;
    tick(6);
    check({sdo_oe, sdo_out}, 2'h2);
    end_of_test();
  end
endmodule
